// >>> design/power_loss_recovery_control.sv
`timescale 1ns/1ps
// Behaviour
// - in soft or mechanical off, standby rail is sampled every cycle
// - standby valid a full 30 s after off: orderly switch-off
// - standby lost inside the 30 s window: AC power loss
// - mode picks turn on, remain off or last state on return
// - the 30 s window matters only in last-state mode
// - loss within 30 s of shutdown leaves last state recorded as off
// - without a standby rail the mode setting has no effect on power-up after a loss
// - active-low supply enable output switches the main supply on
module power_loss_recovery_control
  import power_loss_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic standby_present,
  input wire logic standby_supported,
  input wire logic [1:0] recovery_mode,
  input wire logic power_on_request,
  input wire logic shutdown_request,
  input wire logic carrier_power_good,
  output logic main_supply_enable_n,
  output logic sequencing_active,
  output logic last_state_on,
  output logic power_loss_detected,
  output logic orderly_off_detected
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    phase_type phase;
    logic supply_enable_n;
    logic sequencing;
    logic last_on;
    logic loss_seen;
    logic orderly_seen;
    logic standby_prev;
  } ctrl_state_type;

  ctrl_state_type state;
  ctrl_state_type next_state;
  logic window_start;
  logic window_run;
  logic window_expired;
  logic standby_returned;
  logic want_on;

  standby_window_timer window_timer (
    .core_clk(core_clk),
    .reset(reset),
    .start(window_start),
    .run(window_run),
    .expired(window_expired)
  );

  assign standby_returned = standby_present && !state.standby_prev;

  // ****************************************************************
  // recovery decision
  // ****************************************************************
  always_comb begin
    case (recovery_mode)
      MODE_TURN_ON: want_on = 1'b1;
      MODE_REMAIN_OFF: want_on = 1'b0;
      MODE_LAST_STATE: want_on = state.last_on;
      default: want_on = 1'b0;
    endcase
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    window_start = 1'b0;
    window_run = 1'b0;
    next_state.standby_prev = standby_present;
    case (state.phase)
      st_running: begin
        if (shutdown_request || !standby_present) begin
          next_state.phase = st_off_watch;
          next_state.supply_enable_n = 1'b1;
          next_state.sequencing = 1'b0;
          next_state.loss_seen = 1'b0;
          next_state.orderly_seen = 1'b0;
          window_start = 1'b1;
          // record is cleared only if shutdown was orderly
          if (shutdown_request) begin
            next_state.last_on = 1'b0;
          end
        end
      end
      st_off_watch: begin
        // only the last-state mode relies on the window
        window_run = (recovery_mode == MODE_LAST_STATE);
        if (!standby_present) begin
          next_state.phase = st_off_idle;
          next_state.loss_seen = 1'b1;
        end else if (window_expired || !window_run) begin
          next_state.phase = st_off_idle;
          next_state.orderly_seen = 1'b1;
        end else if (power_on_request) begin
          next_state.phase = st_wait_good;
          next_state.supply_enable_n = 1'b0;
        end
      end
      st_off_idle: begin
        if (power_on_request && standby_present) begin
          next_state.phase = st_wait_good;
          next_state.supply_enable_n = 1'b0;
        end else if (standby_returned && state.loss_seen) begin
          // without standby the supply itself dictates power-up
          if (!standby_supported || want_on) begin
            next_state.phase = st_wait_good;
            next_state.supply_enable_n = 1'b0;
          end
        end
      end
      st_wait_good: begin
        if (!standby_present && standby_supported) begin
          next_state.phase = st_off_idle;
          next_state.supply_enable_n = 1'b1;
          next_state.loss_seen = 1'b1;
          // a stale orderly flag must not sit beside a fresh loss
          next_state.orderly_seen = 1'b0;
        end else if (carrier_power_good) begin
          next_state.phase = st_running;
          next_state.sequencing = 1'b1;
          next_state.last_on = 1'b1;
        end
      end
      default: begin
        next_state.phase = st_off_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state.phase <= st_off_idle;
      state.supply_enable_n <= RESET_SUPPLY_ENABLE_N;
      state.sequencing <= 1'b0;
      state.last_on <= RESET_LAST_ON;
      state.loss_seen <= 1'b0;
      state.orderly_seen <= 1'b0;
      state.standby_prev <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign main_supply_enable_n = state.supply_enable_n;
  assign sequencing_active = state.sequencing;
  assign last_state_on = state.last_on;
  assign power_loss_detected = state.loss_seen;
  assign orderly_off_detected = state.orderly_seen;

endmodule : power_loss_recovery_control

// >>> design/power_loss_pkg.sv
package power_loss_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned STABLE_WINDOW_S = 30;
  localparam longint unsigned STABLE_WINDOW_CYCLES =
    longint'(STABLE_WINDOW_S) * longint'(CLOCK_HZ);
  localparam int unsigned WINDOW_COUNT_WIDTH = 31;

  // ****************************************************************
  // recovery modes
  // ****************************************************************
  localparam logic [1:0] MODE_TURN_ON = 2'h0;
  localparam logic [1:0] MODE_REMAIN_OFF = 2'h1;
  localparam logic [1:0] MODE_LAST_STATE = 2'h2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RESET_LAST_ON = 1'h0;
  localparam logic RESET_SUPPLY_ENABLE_N = 1'h1;

  typedef enum logic [2:0] {
    st_off_idle,
    st_off_watch,
    st_wait_good,
    st_running
  } phase_type;

endpackage : power_loss_pkg

// >>> design/standby_window_timer.sv
`timescale 1ns/1ps
module standby_window_timer
  import power_loss_pkg::*;
#(
  parameter logic [WINDOW_COUNT_WIDTH-1:0] WINDOW =
    WINDOW_COUNT_WIDTH'(STABLE_WINDOW_CYCLES)
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic run,
  output logic expired
);

  typedef struct packed {
    logic [WINDOW_COUNT_WIDTH-1:0] count;
    logic expired;
  } timer_state_type;

  timer_state_type state;
  timer_state_type next_state;

  always_comb begin
    next_state = state;
    if (start) begin
      next_state.count = '0;
      next_state.expired = 1'b0;
    end else if (run && !state.expired) begin
      if (state.count >= WINDOW - 1'b1) begin
        next_state.expired = 1'b1;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign expired = state.expired;

endmodule : standby_window_timer

// >>> tb/power_loss_chk.sv
`timescale 1ns/1ps
module power_loss_chk
  import power_loss_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic standby_present,
  input wire logic standby_supported,
  input wire logic [1:0] recovery_mode,
  input wire logic power_on_request,
  input wire logic shutdown_request,
  input wire logic carrier_power_good,
  input wire logic main_supply_enable_n,
  input wire logic sequencing_active,
  input wire logic last_state_on,
  input wire logic power_loss_detected,
  input wire logic orderly_off_detected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  supply_on_a: assert property (
    sequencing_active |-> !main_supply_enable_n) else $error("run no supply");
  good_gate_a: assert property (
    $rose(sequencing_active) |-> $past(carrier_power_good) && last_state_on)
    else $error("run without power good");
  off_record_a: assert property (
    sequencing_active && shutdown_request |=>
    main_supply_enable_n && !last_state_on) else $error("bad shutdown");
  flag_excl_a: assert property (
    !(power_loss_detected && orderly_off_detected)) else $error("both flags");
  window_loss_a: assert property (
    recovery_mode == MODE_LAST_STATE && $fell(sequencing_active)
    ##[1:8] $fell(standby_present) |=> power_loss_detected)
    else $error("loss missed");
  quick_off_a: assert property (
    recovery_mode == MODE_TURN_ON && standby_present &&
    $fell(sequencing_active) |-> ##[1:2] orderly_off_detected)
    else $error("no orderly flag");
  at_supply_a: assert property (
    !standby_supported && $rose(standby_present) |->
    ##[1:4] !main_supply_enable_n) else $error("no power up");
  stay_off_a: assert property (
    standby_supported && recovery_mode == MODE_REMAIN_OFF &&
    $rose(standby_present) |-> main_supply_enable_n[*4])
    else $error("left off state");
  cover property ($rose(power_loss_detected));
  cover property ($rose(orderly_off_detected));
  cover property ($rose(sequencing_active));
endmodule : power_loss_chk
bind power_loss_recovery_control power_loss_chk chk_i (.*);

// >>> tb/carrier_supply_model.sv
`timescale 1ns/1ps
module carrier_supply_model #(
  parameter int DELAY = 4
) (
  input wire logic core_clk,
  input wire logic main_supply_enable_n,
  input wire logic standby_present,
  output logic carrier_power_good
);
  int count = 0;
  // enable is inverted on the carrier; rails need time to settle
  always @(posedge core_clk) begin
    if (main_supply_enable_n || !standby_present) begin
      count <= 0;
    end else if (count < DELAY) begin
      count <= count + 1;
    end
  end
  assign carrier_power_good = (count == DELAY);
endmodule : carrier_supply_model

// >>> tb/power_loss_recovery_control_tb_top.sv
`timescale 1ns/1ps
module power_loss_recovery_control_tb_top;
  import power_loss_pkg::*;
  logic core_clk = 0, reset = 1, standby_present = 1, standby_supported = 1;
  logic [1:0] recovery_mode = MODE_TURN_ON;
  logic power_on_request = 0, shutdown_request = 0, carrier_power_good;
  logic main_supply_enable_n, sequencing_active, last_state_on;
  logic power_loss_detected, orderly_off_detected;
  int bad_count = 0, compares = 0;
  power_loss_recovery_control DUT (.*);
  carrier_supply_model #(.DELAY(4)) supply (.*);
  localparam int WIN = 100;
  // shortened window so the last-state expiry path is reachable
  defparam DUT.window_timer.WINDOW = 31'd100;
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(string n, logic e, logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic start(logic [1:0] m, logic sup);
    reset = 1;
    recovery_mode = m;
    standby_supported = sup;
    standby_present = 1;
    cyc(10);
    reset = 0;
    cyc(1);
    power_on_request = 1;
    cyc(1);
    power_on_request = 0;
    chk("enable_n", 0, main_supply_enable_n);
    cyc(6);
    chk("running", 1, sequencing_active);
    chk("last_on", 1, last_state_on);
  endtask : start
  task automatic t_orderly(logic [1:0] m, logic drop);
    start(m, 1);
    shutdown_request = 1;
    cyc(1);
    shutdown_request = 0;
    chk("enable_n", 1, main_supply_enable_n);
    chk("last_on", 0, last_state_on);
    cyc(2);
    standby_present = !drop;
    cyc(2);
    chk("loss", drop, power_loss_detected);
    chk("orderly", !drop, orderly_off_detected);
    standby_present = 1;
    cyc(6);
    chk("stay off", 1, main_supply_enable_n);
    $display("orderly off test done");
  endtask : t_orderly
  task automatic t_run_loss(logic [1:0] m, logic sup, logic exp_n);
    start(m, sup);
    standby_present = 0;
    cyc(3);
    chk("last_on", 1, last_state_on);
    standby_present = 1;
    cyc(6);
    chk("restore", exp_n, main_supply_enable_n);
    $display("power loss test done");
  endtask : t_run_loss
  task automatic t_window();
    start(MODE_LAST_STATE, 1);
    shutdown_request = 1;
    cyc(1);
    shutdown_request = 0;
    cyc(WIN - 1);
    chk("orderly early", 0, orderly_off_detected);
    cyc(3);
    chk("orderly", 1, orderly_off_detected);
    chk("loss", 0, power_loss_detected);
    $display("window expiry test done");
  endtask : t_window
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  initial begin
    cyc(2000);
    bad_count++;
    stop_test();
  end
  initial begin
    t_orderly(MODE_TURN_ON, 0);
    t_orderly(MODE_LAST_STATE, 1);
    t_run_loss(MODE_TURN_ON, 1, 0);
    t_run_loss(MODE_REMAIN_OFF, 1, 1);
    t_run_loss(MODE_LAST_STATE, 1, 0);
    t_run_loss(MODE_REMAIN_OFF, 0, 0);
    t_run_loss(2'h3, 1, 1);
    t_window();
    stop_test();
  end
endmodule : power_loss_recovery_control_tb_top
